/* File: dds_sweep_and_update_sync_tb_top.sv */
// testbench: register port tasks and sweep, update and clock scenarios
`timescale 1ns/1ps
module dds_sweep_and_update_sync_tb_top;
   logic        clk_sys_i;
   logic        reset_n_i;
   logic        clk_en;
   logic [3:0]  addr;
   logic [31:0] wdata;
   logic        wr;
   logic        rd;
   logic [31:0] rdata;
   logic        upd_req;
   logic [1:0]  ps_req;
   logic        strobe;
   logic [1:0]  ps;
   logic        sync;
   logic        half;
   logic        sleep;
   logic [31:0] phase;
   int          fail_count;
   int          checks_done;
   logic [31:0] f0;
   logic [31:0] f1;
   logic [31:0] stp;
   int          rt;

   dsw_core u_dsw_core (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en), .reg_addr_i(addr),
      .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .update_strobe_i(strobe),
      .profile_select_0_i(ps[0]), .profile_select_1_i(ps[1]), .sync_clock_out_o(sync),
      .sys_clk_half_o(half), .full_sleep_o(sleep), .phase_incr_o(phase));
   dsw_ctrl_model u_dsw_ctrl_model (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .sync_clock_i(sync),
      .upd_req_i(upd_req), .ps_req_i(ps_req), .update_strobe_o(strobe), .profile_o(ps));

   // ---------------------------------------------------------------
   // clock, closing and compare
   // ---------------------------------------------------------------
   initial begin
      clk_sys_i = 1'b0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // ---------------------------------------------------------------
   // register port: one-cycle strobes, read data in the next cycle
   // ---------------------------------------------------------------
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk_sys_i);
      wr <= 1'b0;
   endtask

   task automatic rd_val(input logic [3:0] a, output logic [31:0] v);
      @(posedge clk_sys_i);
      rd   <= 1'b1;
      addr <= a;
      @(posedge clk_sys_i);
      rd <= 1'b0;
      #1;
      v = rdata;
   endtask

   task automatic rd_reg(input logic [3:0] a, input logic [31:0] exp);
      logic [31:0] v;
      rd_val(a, v);
      chk(v, exp);
   endtask

   // update request goes through the controller model, then settles
   task automatic do_update();
      @(posedge clk_sys_i);
      upd_req <= 1'b1;
      @(posedge clk_sys_i);
      upd_req <= 1'b0;
      repeat (48) @(posedge clk_sys_i);
      #1;
   endtask

   // counts sync rises over 64 system cycles
   task automatic sync_rises(input logic [31:0] exp);
      logic        prev;
      logic [31:0] n;
      prev = sync;
      n = 0;
      repeat (64) begin
         @(posedge clk_sys_i);
         #1;
         if (sync === 1'b1 && prev === 1'b0) n++;
         prev = sync;
      end
      chk(n, exp);
   endtask

   // ---------------------------------------------------------------
   // watchdog: the whole run needs about 1200 cycles
   // ---------------------------------------------------------------
   initial begin
      repeat (20000) @(posedge clk_sys_i);
      fail_count++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      fail_count = 0;
      checks_done = 0;
      reset_n_i = 1'b0;
      {addr, wdata, wr, rd, upd_req, ps_req} = '0;
      clk_en = 1'b1;
      repeat (10) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      rd_reg(dsw_pkg::OFF_CTRL, {16'h0000, dsw_pkg::CTL_RESET});
      rd_reg(4'h3, 32'h0000_0000);
      wr_reg(dsw_pkg::OFF_ACTIVE_TW, 32'hDEAD_BEEF);
      rd_reg(dsw_pkg::OFF_ACTIVE_TW, 32'h0000_0000);
      sync_rises(32'h8);
      for (int p = 0; p < 4; p++) wr_reg(dsw_pkg::OFF_TUNE0 + 4'(p), 32'h1111_1111 * (p + 1));
      rd_reg(dsw_pkg::OFF_ACTIVE_TW, 32'h0000_0000);
      rd_reg(dsw_pkg::OFF_TUNE0 + 4'h2, 32'h3333_3333);
      do_update();
      chk(phase, 32'h1111_1111);
      for (int p = 1; p < 4; p++) begin
         ps_req <= 2'(p);
         repeat (48) @(posedge clk_sys_i);
         #1;
         chk(phase, 32'h1111_1111 * (p + 1));
      end
      ps_req <= 2'h0;
      repeat (48) @(posedge clk_sys_i);
      // up and down sweeps at two rates
      for (int i = 0; i < 2; i++) begin
         stp = (i == 0) ? 32'h0000_0100 : 32'hFFFF_FF00;
         rt  = (i == 0) ? 1 : 3;
         wr_reg(dsw_pkg::OFF_STEP, stp);
         wr_reg(dsw_pkg::OFF_RATE, 32'(rt));
         rd_reg(dsw_pkg::OFF_STEP, stp);
         do_update();
         rd_val(dsw_pkg::OFF_FACC, f0);
         // the two samples lie exactly 40 * rate edges apart, whatever the sync phase
         repeat (8 * rt * 5 - 2) @(posedge clk_sys_i);
         rd_val(dsw_pkg::OFF_FACC, f1);
         chk(f1 - f0, 32'd5 * (stp << 1));
         // clock enable low must freeze the running sweep
         @(posedge clk_sys_i);
         clk_en <= 1'b0;
         @(posedge clk_sys_i);
         #1;
         f0 = phase;
         repeat (40) @(posedge clk_sys_i);
         #1;
         chk(phase, f0);
         @(posedge clk_sys_i);
         clk_en <= 1'b1;
         wr_reg(dsw_pkg::OFF_RATE, 32'h0);
         do_update();
         rd_val(dsw_pkg::OFF_FACC, f0);
         repeat (64) @(posedge clk_sys_i);
         rd_reg(dsw_pkg::OFF_FACC, f0);
         chk(phase, 32'h1111_1111 + f0);
         rd_reg(dsw_pkg::OFF_TUNE0, 32'h1111_1111);
      end
      wr_reg(dsw_pkg::OFF_CTRL, 32'h0000_0118);
      do_update();
      rd_reg(dsw_pkg::OFF_FACC, 32'h0000_0000);
      chk(phase, 32'h1111_1111);
      wr_reg(dsw_pkg::OFF_CTRL, 32'h0000_0058);
      do_update();
      chk({31'h0, half}, 32'h1);
      sync_rises(32'h4);
      rd_reg(dsw_pkg::OFF_STATUS, 32'h0000_0002);
      wr_reg(dsw_pkg::OFF_CTRL, 32'h0000_001C);
      do_update();
      chk({31'h0, sleep}, 32'h1);
      sync_rises(32'h0);
      end_sim();
   end
endmodule

/* File: dsw_core.sv */
// sweep accumulator, sync divider and buffered register update for the synthesizer core
`timescale 1ns/1ps

module dsw_core (
   input  wire logic                   clk_sys_i,
   input  wire logic                   reset_n_i,
   input  wire logic                   clk_en_i,
   input  wire logic [3:0]             reg_addr_i,
   input  wire logic [31:0]            reg_wdata_i,
   input  wire logic                   reg_wr_i,
   input  wire logic                   reg_rd_i,
   output logic      [31:0]            reg_rdata_o,
   input  wire logic                   update_strobe_i,
   input  wire logic                   profile_select_0_i,
   input  wire logic                   profile_select_1_i,
   output logic                        sync_clock_out_o,
   output logic                        sys_clk_half_o,
   output logic                        full_sleep_o,
   output logic      [dsw_pkg::TW_W-1:0] phase_incr_o
);

   // ---------------------------------------------------------------
   // register port and buffer memory
   // ---------------------------------------------------------------
   dsw_pkg::dsw_bus_req_t req;
   dsw_pkg::dsw_regs_t    buf_q;
   dsw_pkg::dsw_regs_t    act_q;
   logic [dsw_pkg::TW_W-1:0]   facc_q;
   logic [dsw_pkg::RATE_W-1:0] count_q;
   logic [2:0]                 div_q;
   logic [2:0]                 pre_q;
   logic                       half_q;
   logic [1:0]                 ps_q;
   logic [31:0]                rdata_q;

   assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

   // tuning word slot index from an offset
   function automatic logic [1:0] tune_idx(input logic [3:0] a);
      logic [3:0] d;
      d = a - dsw_pkg::OFF_TUNE0;
      return d[1:0];
   endfunction

   function automatic logic is_tune(input logic [3:0] a);
      return (a >= dsw_pkg::OFF_TUNE0) && (a < dsw_pkg::OFF_ACTIVE_TW);
   endfunction

   // ---------------------------------------------------------------
   // clock tree: reference divider, sync divider, sleep gate
   // ---------------------------------------------------------------
   wire logic ref_div_en = act_q.ctrl[dsw_pkg::CTL_REFDIV_BIT];
   wire logic sleep      = &act_q.ctrl[dsw_pkg::CTL_PD_MSB:dsw_pkg::CTL_PD_LSB];
   // system clock tick: every reference cycle, or every other one when halved
   wire logic sys_tick   = clk_en_i && (!ref_div_en || half_q);
   wire logic core_tick  = sys_tick && !sleep;
   // update edge is the tick that lifts the sync pin (3 -> 4), so outside logic
   // clocked on the pin's rising edge and the core agree on when pins are taken
   wire logic sync_rise  = core_tick && (div_q == (dsw_pkg::SYNC_DIV_HALF - 3'h1));

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         half_q <= 1'b0;
         div_q  <= 3'h0;
      end else if (clk_en_i) begin
         half_q <= ref_div_en ? !half_q : 1'b0;
         if (core_tick) begin
            div_q <= div_q + 3'h1;
         end
      end
   end

   assign sync_clock_out_o = div_q >= dsw_pkg::SYNC_DIV_HALF;
   assign sys_clk_half_o   = ref_div_en;
   assign full_sleep_o     = sleep;

   // ---------------------------------------------------------------
   // update request: strobe or profile change, taken at sync edge
   // ---------------------------------------------------------------
   // pins are sampled only at sync edges, so a change means a level differing from the last sample
   wire logic [1:0] ps_now    = {profile_select_1_i, profile_select_0_i};
   wire logic       ps_change = ps_now != ps_q;
   wire logic       do_update = sync_rise && (update_strobe_i || ps_change);

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ps_q <= 2'h0;
      end else if (sync_rise) begin
         ps_q <= ps_now;
      end
   end

   // ---------------------------------------------------------------
   // buffer writes: host sees the buffer, core sees only act_q
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         buf_q <= '{ctrl: dsw_pkg::CTL_RESET, default: '0};
      end else if (clk_en_i && req.wr) begin
         if (req.addr == dsw_pkg::OFF_CTRL) begin
            buf_q.ctrl <= req.wdata[15:0];
         end else if (req.addr == dsw_pkg::OFF_STEP) begin
            buf_q.step <= req.wdata;
         end else if (req.addr == dsw_pkg::OFF_RATE) begin
            buf_q.rate <= req.wdata[dsw_pkg::RATE_W-1:0];
         end else if (is_tune(req.addr)) begin
            buf_q.tune[tune_idx(req.addr)] <= req.wdata;
         end
      end
   end

   // whole buffer copied in one cycle, not only touched fields
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         act_q <= '{ctrl: dsw_pkg::CTL_RESET, default: '0};
      end else if (do_update) begin
         act_q <= buf_q;
      end
   end

   // ---------------------------------------------------------------
   // sweep engine, advanced at sync rate (system clock / 8)
   // ---------------------------------------------------------------
   wire logic autoclr   = act_q.ctrl[dsw_pkg::CTL_AUTOCLR];
   wire logic rate_zero = act_q.rate == '0;
   wire logic expire    = sync_rise && !rate_zero && (count_q <= 16'h0001);
   // step weighs two tuning lsbs, so it enters shifted left by one
   wire logic [dsw_pkg::TW_W-1:0] step_w = {act_q.step[dsw_pkg::TW_W-2:0], 1'b0};

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         count_q <= '0;
         facc_q  <= '0;
      end else if (autoclr && clk_en_i) begin
         facc_q  <= '0;
         count_q <= act_q.rate;
      end else if (expire) begin
         count_q <= act_q.rate;
         facc_q  <= facc_q + step_w;
      end else if (sync_rise && !rate_zero) begin
         count_q <= count_q - 16'h0001;
      end
      // rate zero: neither sweep branch fires, accumulator holds unless autoclear is set
   end

   // start word stays in act_q untouched; only facc_q moves
   wire logic [dsw_pkg::TW_W-1:0] start_tw = act_q.tune[ps_q];
   assign phase_incr_o = start_tw + facc_q;

   // ---------------------------------------------------------------
   // readback, one cycle after the read strobe
   // ---------------------------------------------------------------
   logic [31:0] rd_mux;
   always_comb begin
      if (req.addr == dsw_pkg::OFF_CTRL) begin
         rd_mux = {16'h0000, buf_q.ctrl};
      end else if (req.addr == dsw_pkg::OFF_STEP) begin
         rd_mux = buf_q.step;
      end else if (req.addr == dsw_pkg::OFF_RATE) begin
         rd_mux = {16'h0000, buf_q.rate};
      end else if (is_tune(req.addr)) begin
         rd_mux = buf_q.tune[tune_idx(req.addr)];
      end else if (req.addr == dsw_pkg::OFF_ACTIVE_TW) begin
         rd_mux = phase_incr_o;
      end else if (req.addr == dsw_pkg::OFF_FACC) begin
         rd_mux = facc_q;
      end else if (req.addr == dsw_pkg::OFF_STATUS) begin
         rd_mux = {28'h0000000, ps_q, ref_div_en, sleep};
      end else begin
         rd_mux = 32'h00000000;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rdata_q <= '0;
      end else if (clk_en_i) begin
         rdata_q <= req.rd ? rd_mux : 32'h00000000;
      end
   end
   assign reg_rdata_o = rdata_q;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   property p_update_copies;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      do_update |=> (act_q == $past(buf_q));
   endproperty
   a_update_copies: assert property (p_update_copies) else $error("update did not copy buffer");

   property p_no_update_off_sync;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !sync_rise |=> $stable(act_q);
   endproperty
   a_no_update_off_sync: assert property (p_no_update_off_sync) else $error("register changed off sync");

   property p_profile_change;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (sync_rise && ps_now != ps_q) |-> do_update;
   endproperty
   a_profile_change: assert property (p_profile_change) else $error("profile change missed");

   property p_step_add;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (expire && !autoclr) |=> facc_q == $past(facc_q) + $past(step_w);
   endproperty
   a_step_add: assert property (p_step_add) else $error("step not added");

   property p_rate_zero_hold;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rate_zero && !autoclr) |=> $stable(facc_q);
   endproperty
   a_rate_zero_hold: assert property (p_rate_zero_hold) else $error("accumulator moved at rate zero");

   property p_autoclr;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (autoclr && clk_en_i) |=> facc_q == '0;
   endproperty
   a_autoclr: assert property (p_autoclr) else $error("autoclear failed");

   property p_reload;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (expire && !autoclr) |=> count_q == $past(act_q.rate);
   endproperty
   a_reload: assert property (p_reload) else $error("countdown not reloaded");

   property p_sync_period;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (sync_rise && !ref_div_en) ##1 (clk_en_i && !sleep && !ref_div_en)[*8]
         |-> sync_rise;
   endproperty
   a_sync_period: assert property (p_sync_period) else $error("sync period not eight");

   property p_incr;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      phase_incr_o == act_q.tune[ps_q] + facc_q;
   endproperty
   a_incr: assert property (p_incr) else $error("phase increment wrong");

   // update must land on the rising edge of the sync pin
   property p_sync_edge;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      sync_rise |=> (sync_clock_out_o && !$past(sync_clock_out_o));
   endproperty
   a_sync_edge: assert property (p_sync_edge) else $error("update not on sync rising edge");

   // countdown steps down by one per sync tick until it expires
   property p_count_down;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (sync_rise && !rate_zero && !autoclr && count_q > 16'h0001) |=> count_q == $past(count_q) - 16'h0001;
   endproperty
   a_count_down: assert property (p_count_down) else $error("countdown did not decrement");

   // between sync ticks the accumulator may only move by autoclear
   property p_step_on_sync_only;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (!sync_rise && !autoclr) |=> $stable(facc_q);
   endproperty
   a_step_on_sync_only: assert property (p_step_on_sync_only) else $error("accumulator moved off sync");

   // step weight: accumulator moves by the step word with one zero below it
   property p_step_weight;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (expire && !autoclr) |=> (facc_q - $past(facc_q)) == {$past(act_q.step[dsw_pkg::TW_W-2:0]), 1'b0};
   endproperty
   a_step_weight: assert property (p_step_weight) else $error("step weight wrong");

   // countdown parks with the accumulator while the rate word is zero
   property p_count_hold_zero;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (rate_zero && !autoclr) |=> $stable(count_q);
   endproperty
   a_count_hold_zero: assert property (p_count_hold_zero) else $error("countdown moved at rate zero");

   // start words only change through an update, never by sweeping
   property p_start_kept;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      !do_update |=> $stable(act_q.tune);
   endproperty
   a_start_kept: assert property (p_start_kept) else $error("start word changed without update");

   // autoclear drops the output back onto the stored start word
   property p_autoclr_start;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (autoclr && clk_en_i && !do_update) |=> phase_incr_o == $past(start_tw);
   endproperty
   a_autoclr_start: assert property (p_autoclr_start) else $error("autoclear left output off start");

   // no ticks reach the sync divider while asleep
   property p_sleep_freeze;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      sleep |=> $stable(div_q);
   endproperty
   a_sleep_freeze: assert property (p_sleep_freeze) else $error("divider ran in sleep");

   // halved system clock: the divider never moves on two cycles running
   property p_half_rate;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (ref_div_en && clk_en_i && !sleep && $changed(div_q)) |=> $stable(div_q);
   endproperty
   a_half_rate: assert property (p_half_rate) else $error("divider ticked twice when halved");

   // profile pins are latched on every sync tick
   property p_profile_pick;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      sync_rise |=> ps_q == $past(ps_now);
   endproperty
   a_profile_pick: assert property (p_profile_pick) else $error("profile pins not latched");

   // host writes stay in the buffer until an update
   property p_buffer_only;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (clk_en_i && reg_wr_i && !do_update) |=> $stable(act_q);
   endproperty
   a_buffer_only: assert property (p_buffer_only) else $error("write reached active registers");

   // readback of the step register shows the buffer copy
   property p_rd_buffer;
      @(posedge clk_sys_i) disable iff (!reset_n_i)
      (clk_en_i && reg_rd_i && reg_addr_i == dsw_pkg::OFF_STEP) |=> reg_rdata_o == $past(buf_q.step);
   endproperty
   a_rd_buffer: assert property (p_rd_buffer) else $error("step readback not from buffer");

   c_update:  cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) do_update && update_strobe_i);
   c_profile: cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) do_update && ps_change);
   c_expire:  cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) expire);
   c_sleep:   cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) sleep);
   c_half:    cover property (@(posedge clk_sys_i) disable iff (!reset_n_i) sync_rise && ref_div_en);
endmodule

/* File: dsw_ctrl_model.sv */
// controller model: drives update strobe and profile pins in step with the sync clock
`timescale 1ns/1ps
module dsw_ctrl_model (
   input  wire logic       clk_sys_i,
   input  wire logic       reset_n_i,
   input  wire logic       sync_clock_i,
   input  wire logic       upd_req_i,
   input  wire logic [1:0] ps_req_i,
   output logic            update_strobe_o,
   output logic [1:0]      profile_o
);
   logic sync_q;
   logic pend_q;
   wire  sync_fall = sync_q & ~sync_clock_i;

   // ---------------------------------------------------------------
   // pins move only at a sync fall, so they stand still across the rise
   // ---------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sync_q          <= 1'b0;
         pend_q          <= 1'b0;
         update_strobe_o <= 1'b0;
         profile_o       <= 2'h0;
      end else begin
         sync_q <= sync_clock_i;
         if (sync_fall) begin
            update_strobe_o <= pend_q | upd_req_i;
            profile_o       <= ps_req_i;
            pend_q          <= 1'b0;
         end else if (upd_req_i) begin
            pend_q <= 1'b1;
         end
      end
   end
endmodule

/* File: dsw_pkg.sv */
// package: constants, register offsets and carrier types for the sweep and update block
package dsw_pkg;
   // ---------------------------------------------------------------
   // widths and timing
   // ---------------------------------------------------------------
   localparam int unsigned TW_W          = 32;
   localparam int unsigned RATE_W        = 16;
   localparam int unsigned CLK_MHZ       = 100;
   localparam int unsigned SYNC_DIV      = 8;
   localparam logic [2:0]  SYNC_DIV_LAST = 3'h7;
   localparam logic [2:0]  SYNC_DIV_HALF = 3'h4;
   localparam int unsigned NUM_PROFILES  = 4;

   // ---------------------------------------------------------------
   // buffer, active-word and status register offsets (register port)
   // ---------------------------------------------------------------
   localparam logic [3:0] OFF_CTRL      = 4'h0;
   localparam logic [3:0] OFF_STEP      = 4'h1;
   localparam logic [3:0] OFF_RATE      = 4'h2;
   localparam logic [3:0] OFF_TUNE0     = 4'h4;
   localparam logic [3:0] OFF_ACTIVE_TW = 4'h8;
   localparam logic [3:0] OFF_FACC      = 4'h9;
   localparam logic [3:0] OFF_STATUS    = 4'hA;

   // ---------------------------------------------------------------
   // control_function_reg field positions and reset values
   // ---------------------------------------------------------------
   localparam int unsigned CTL_PD_LSB     = 2;
   localparam int unsigned CTL_PD_MSB     = 4;
   localparam int unsigned CTL_REFDIV_BIT = 6;
   localparam int unsigned CTL_AUTOCLR    = 8;
   localparam logic [15:0] CTL_RESET      = 16'h0018;
   localparam logic [15:0] STEP_RESET_HI  = 16'h0000;

   typedef struct packed {
      logic [3:0]  addr;
      logic [31:0] wdata;
      logic        wr;
      logic        rd;
   } dsw_bus_req_t;

   typedef struct packed {
      logic [15:0]     ctrl;
      logic [TW_W-1:0] step;
      logic [RATE_W-1:0] rate;
      logic [NUM_PROFILES-1:0][TW_W-1:0] tune;
   } dsw_regs_t;
endpackage
